// [audio_host.sv]
/*
 * audio host model: bit clock, word clock and data in all four formats.
 * assumes 32 bit clocks of 125 ns per channel, then a pause that sets the ratio.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_host import audio_in_pkg::*; (
    // control
    input wire logic run,
    input wire logic [1:0] fmt,
    input wire logic [11:0] ratio,
    input wire logic [23:0] left,
    input wire logic [23:0] right,
    // pins
    output logic bck,
    output logic wc,
    output logic sd
);
    logic [23:0] w;
    int k;
    initial begin
        bck = 1'b0;
        wc = 1'b0;
        sd = 1'b0;
        #37;
        forever begin
            // bit clock stands still while not running
            if (!run) #125;
            for (int h = 0; h < 2 && run; h++) begin
                // left is word clock high, low in i2s
                wc = (h == 0) ^ (fmt == FMT_I2S);
                w = (h == 0) ? left : right;
                k = (fmt == FMT_LSB16) ? 16 : (fmt == FMT_LSB24) ? 8 :
                    (fmt == FMT_I2S) ? 1 : 0;
                for (int i = 0; i < 32; i++) begin
                    // unused slots carry zero
                    sd = (i >= k && i - k < 24) ? w[23 - (i - k)] : 1'b0;
                    #62.5 bck = 1'b1;
                    #62.5 bck = 1'b0;
                end
                // clock still for the rest of the half period: master clock at the ratio
                #(ratio * 50.0 - 4000.0);
            end
        end
    end
endmodule // audio_host

`default_nettype wire

// [audio_in_pkg.sv]
/*
 * constants shared by the serial audio input block: register map,
 * field layout, speed and format encodings, timing counts.
 * assumes a 10 MHz master clock driving the register side.
 */
`default_nettype none

package audio_in_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned MCLK_HZ = 10_000_000;
    localparam int unsigned WORD_TIMEOUT_US = 200;
    localparam int unsigned WORD_TIMEOUT_CYC = WORD_TIMEOUT_US * (MCLK_HZ / 1_000_000);
    localparam int unsigned HEARTBEAT_W = 4;
    localparam int unsigned LINK_WATCHDOG = 64;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SPEED_NORMAL = 2'h0;
    localparam logic [1:0] SPEED_DOUBLE = 2'h1;
    localparam logic [1:0] SPEED_HALF = 2'h2;
    localparam logic [1:0] SPEED_AUTO = 2'h3;
    localparam logic [1:0] FMT_LSB16 = 2'h0;
    localparam logic [1:0] FMT_LSB24 = 2'h1;
    localparam logic [1:0] FMT_MSB24 = 2'h2;
    localparam logic [1:0] FMT_I2S = 2'h3;
    localparam int unsigned SAMPLE_W = 24;
    localparam int unsigned RATIO_W = 12;
    localparam logic [11:0] RATIO_DOUBLE_MAX = 12'h1BF;
    localparam logic [11:0] RATIO_NORMAL_MAX = 12'h37F;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RATIO_OFFSET = 8'h08;
    localparam logic [7:0] LEFT_OFFSET = 8'h0C;
    localparam logic [7:0] RIGHT_OFFSET = 8'h10;
    localparam int unsigned CTRL_SPEED_LSB = 0;
    localparam int unsigned CTRL_FORMAT_LSB = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int unsigned STAT_SPEED_LSB = 0;
    localparam int unsigned STAT_DETECT_LSB = 2;
    localparam int unsigned STAT_WORD_BIT = 4;
    localparam int unsigned STAT_RESET_BIT = 5;
    localparam int unsigned STAT_LOST_BIT = 6;

    // ratio in master clocks per word clock period to speed mode
    function automatic logic [1:0] classify_ratio(input logic [11:0] r);
        if (r <= RATIO_DOUBLE_MAX) begin
            classify_ratio = SPEED_DOUBLE;
        end else if (r <= RATIO_NORMAL_MAX) begin
            classify_ratio = SPEED_NORMAL;
        end else begin
            classify_ratio = SPEED_HALF;
        end
    endfunction
endpackage

`default_nettype wire

// [audio_serial_input.sv]
/*
 * serial audio input port with speed mode selection and clock watch.
 * assumes an apb master on MCLK and an audio host driving bit clock,
 * word clock and data; the bit clock is a domain of its own.
 */
// Operation
// - speed field picks normal, double, half or automatic detection.
// - automatic mode maps measured ratio to double, normal or half.
// - ratio measured by counting master clocks per word clock period.
// - master clock loss while powered up forces mid level at once, and reset once the master clock returns.
// - after power-down release stay in reset until clocks present.
// - data taken msb first, two's complement, on rising bit clock.
// - format field picks 16 lsb, 24 lsb, 24 msb or i2s.
// - power-down pin low resets datapath and interface state.
// - power-down pin low returns speed and format to defaults.
`timescale 1ns/1ps
`default_nettype none

module audio_serial_input import audio_in_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // audio pins
    input wire logic POWER_DOWN_PIN_N,
    input wire logic SERIAL_BIT_CLOCK,
    input wire logic CHANNEL_WORD_CLOCK,
    input wire logic SERIAL_SAMPLE_INPUT,
    // downstream filter
    output logic [23:0] SAMPLE_LEFT,
    output logic [23:0] SAMPLE_RIGHT,
    output logic SAMPLE_VALID,
    output logic [1:0] ACTIVE_SPEED,
    output logic DATAPATH_RESET,
    output logic MID_LEVEL_OUT
);
    typedef enum logic [1:0] {ST_DOWN, ST_WAIT, ST_RUN} clk_state_t;

    localparam logic [11:0] WORD_TIMEOUT = 12'(WORD_TIMEOUT_CYC);
    localparam logic [6:0] WATCHDOG_LAST = 7'(LINK_WATCHDOG - 1);

    logic pd_up;
    logic word_s;
    logic pair_s;
    logic lost_s;
    logic word_prev_q;
    logic word_rise;
    logic word_edge;
    logic [3:0] ctrl_q;
    logic [1:0] speed_sel;
    logic [1:0] fmt_sel;
    logic [11:0] cnt_q;
    logic [11:0] ratio_q;
    logic ratio_valid_q;
    logic [1:0] detect_q;
    logic [11:0] idle_q;
    logic word_present;
    clk_state_t state_q;
    clk_state_t state_d;
    logic dp_reset_q;
    logic pair_prev_q;
    logic [HEARTBEAT_W-1:0] hb_cnt_q;
    logic hb_q;
    logic apb_wr;
    logic apb_setup;
    logic mapped;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] ctrl_addr;
    logic [ADDR_W-1:0] status_addr;
    logic [ADDR_W-1:0] ratio_addr;
    logic [ADDR_W-1:0] left_addr;
    logic [ADDR_W-1:0] right_addr;
    logic pd_link;
    logic hb_link;
    logic fmt0_link;
    logic fmt1_link;
    logic [1:0] fmt_prev_q;
    logic [1:0] fmt_link_q;
    logic hb_prev_q;
    logic [6:0] wd_q;
    logic lost_q;
    logic [23:0] hold_left;
    logic [23:0] hold_right;
    logic pair_tgl;

    // ------------------------------------------------------------
    // pin and link-domain flag synchronisers into the register domain
    // ------------------------------------------------------------
    sync_bit u_pd_sync (
        .clk(MCLK),
        .arst_n(ARST_N),
        .d(POWER_DOWN_PIN_N),
        .q(pd_up)
    );
    sync_bit u_word_sync (
        .clk(MCLK),
        .arst_n(ARST_N),
        .d(CHANNEL_WORD_CLOCK),
        .q(word_s)
    );
    sync_bit u_pair_sync (
        .clk(MCLK),
        .arst_n(ARST_N),
        .d(pair_tgl),
        .q(pair_s)
    );
    sync_bit u_lost_sync (
        .clk(MCLK),
        .arst_n(ARST_N),
        .d(lost_q),
        .q(lost_s)
    );

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign ctrl_addr = ADDR_W'(CTRL_OFFSET);
    assign status_addr = ADDR_W'(STATUS_OFFSET);
    assign ratio_addr = ADDR_W'(RATIO_OFFSET);
    assign left_addr = ADDR_W'(LEFT_OFFSET);
    assign right_addr = ADDR_W'(RIGHT_OFFSET);
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_setup = PSEL && !PENABLE;
    assign mapped = (PADDR == ctrl_addr) || (PADDR == status_addr) ||
                    (PADDR == ratio_addr) || (PADDR == left_addr) ||
                    (PADDR == right_addr);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign speed_sel = ctrl_q[CTRL_SPEED_LSB +: 2];
    assign fmt_sel = ctrl_q[CTRL_FORMAT_LSB +: 2];

    always_comb begin
        rdata = 32'h00000000;
        if (PADDR == ctrl_addr) begin
            rdata[3:0] = ctrl_q;
        end else if (PADDR == status_addr) begin
            rdata[STAT_SPEED_LSB +: 2] = ACTIVE_SPEED;
            rdata[STAT_DETECT_LSB +: 2] = detect_q;
            rdata[STAT_WORD_BIT] = word_present;
            rdata[STAT_RESET_BIT] = dp_reset_q;
            rdata[STAT_LOST_BIT] = lost_s;
        end else if (PADDR == ratio_addr) begin
            rdata[11:0] = ratio_q;
        end else if (PADDR == left_addr) begin
            rdata[23:0] = SAMPLE_LEFT;
        end else if (PADDR == right_addr) begin
            rdata[23:0] = SAMPLE_RIGHT;
        end
    end

    // read data latched in the setup cycle
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h00000000;
        end else if (apb_setup && !PWRITE) begin
            PRDATA <= rdata;
        end
    end

    // writes are refused while powered down
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q <= CTRL_RESET;
        end else if (!pd_up) begin
            ctrl_q <= CTRL_RESET;
        end else if (apb_wr && PADDR == ctrl_addr) begin
            ctrl_q <= PWDATA[3:0];
        end
    end

    // ------------------------------------------------------------
    // ratio measurement and speed detection
    // ------------------------------------------------------------
    assign word_rise = word_s && !word_prev_q;
    assign word_edge = word_s != word_prev_q;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            word_prev_q <= 1'b0;
            cnt_q <= 12'h000;
            ratio_q <= 12'h000;
            ratio_valid_q <= 1'b0;
            detect_q <= SPEED_NORMAL;
        end else if (!pd_up) begin
            word_prev_q <= word_s;
            cnt_q <= 12'h000;
            ratio_q <= 12'h000;
            ratio_valid_q <= 1'b0;
            detect_q <= SPEED_NORMAL;
        end else begin
            word_prev_q <= word_s;
            if (word_rise) begin
                cnt_q <= 12'h001;
                if (cnt_q != 12'h000) begin
                    ratio_q <= cnt_q;
                    ratio_valid_q <= 1'b1;
                    detect_q <= classify_ratio(cnt_q);
                end
            end else if (cnt_q != 12'h000 && cnt_q != 12'hFFF) begin
                cnt_q <= cnt_q + 12'h001;
            end
        end
    end

    // word clock presence: an edge within the timeout
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            idle_q <= WORD_TIMEOUT;
        end else if (!pd_up) begin
            idle_q <= WORD_TIMEOUT;
        end else if (word_edge) begin
            idle_q <= 12'h000;
        end else if (idle_q != WORD_TIMEOUT) begin
            idle_q <= idle_q + 12'h001;
        end
    end

    assign word_present = ratio_valid_q && (idle_q != WORD_TIMEOUT);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACTIVE_SPEED <= SPEED_NORMAL;
        end else begin
            ACTIVE_SPEED <= (speed_sel == SPEED_AUTO) ? detect_q : speed_sel;
        end
    end

    // ------------------------------------------------------------
    // clock state: power-down, waiting for clocks, running
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_DOWN: if (pd_up) begin
                state_d = ST_WAIT;
            end
            ST_WAIT: if (word_present && !lost_s) begin
                state_d = ST_RUN;
            end
            ST_RUN: if (!word_present || lost_s) begin
                state_d = ST_WAIT;
            end
            default: state_d = ST_DOWN;
        endcase
        if (!pd_up) begin
            state_d = ST_DOWN;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_DOWN;
            dp_reset_q <= 1'b1;
        end else begin
            state_q <= state_d;
            dp_reset_q <= state_d != ST_RUN;
        end
    end

    assign DATAPATH_RESET = dp_reset_q;
    // lost_q is set in the link domain since the register clock is gone then
    assign MID_LEVEL_OUT = dp_reset_q || lost_q;

    // ------------------------------------------------------------
    // stereo pair hand-over to the filter
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pair_prev_q <= 1'b0;
            SAMPLE_LEFT <= 24'h000000;
            SAMPLE_RIGHT <= 24'h000000;
            SAMPLE_VALID <= 1'b0;
        end else begin
            pair_prev_q <= pair_s;
            SAMPLE_VALID <= 1'b0;
            if (!pd_up) begin
                SAMPLE_LEFT <= 24'h000000;
                SAMPLE_RIGHT <= 24'h000000;
            end else if (pair_s != pair_prev_q && state_q == ST_RUN) begin
                // hold registers are stable for half a sample period here
                SAMPLE_LEFT <= hold_left;
                SAMPLE_RIGHT <= hold_right;
                SAMPLE_VALID <= 1'b1;
            end
        end
    end

    // heartbeat for the master clock watchdog
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hb_cnt_q <= '0;
            hb_q <= 1'b0;
        end else begin
            hb_cnt_q <= hb_cnt_q + 1'b1;
            if (&hb_cnt_q) begin
                hb_q <= ~hb_q;
            end
        end
    end

    // ------------------------------------------------------------
    // bit clock domain
    // ------------------------------------------------------------
    sync_bit u_pd_link (
        .clk(SERIAL_BIT_CLOCK),
        .arst_n(ARST_N),
        .d(POWER_DOWN_PIN_N),
        .q(pd_link)
    );
    sync_bit u_hb_link (
        .clk(SERIAL_BIT_CLOCK),
        .arst_n(ARST_N),
        .d(hb_q),
        .q(hb_link)
    );
    sync_bit u_fmt0_link (
        .clk(SERIAL_BIT_CLOCK),
        .arst_n(ARST_N),
        .d(fmt_sel[0]),
        .q(fmt0_link)
    );
    sync_bit u_fmt1_link (
        .clk(SERIAL_BIT_CLOCK),
        .arst_n(ARST_N),
        .d(fmt_sel[1]),
        .q(fmt1_link)
    );

    // both format bits must agree for two bit clocks, so a skewed pair is never used
    always_ff @(posedge SERIAL_BIT_CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fmt_prev_q <= FMT_LSB16;
            fmt_link_q <= FMT_LSB16;
        end else begin
            fmt_prev_q <= {fmt1_link, fmt0_link};
            if ({fmt1_link, fmt0_link} == fmt_prev_q) begin
                fmt_link_q <= fmt_prev_q;
            end
        end
    end

    // master clock watchdog, only while powered up
    always_ff @(posedge SERIAL_BIT_CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            hb_prev_q <= 1'b0;
            wd_q <= 7'h00;
            lost_q <= 1'b0;
        end else begin
            hb_prev_q <= hb_link;
            if (!pd_link || hb_link != hb_prev_q) begin
                wd_q <= 7'h00;
                lost_q <= 1'b0;
            end else if (wd_q == WATCHDOG_LAST) begin
                lost_q <= 1'b1;
            end else begin
                wd_q <= wd_q + 7'h01;
            end
        end
    end

    serial_deframer u_deframer (
        .clk(SERIAL_BIT_CLOCK),
        .arst_n(ARST_N),
        .clear(!pd_link),
        .fmt(fmt_link_q),
        .word_in(CHANNEL_WORD_CLOCK),
        .data_in(SERIAL_SAMPLE_INPUT),
        .left(hold_left),
        .right(hold_right),
        .pair_toggle(pair_tgl)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ctrl_write;
        apb_wr && PADDR == ctrl_addr && pd_up;
    endsequence

    sequence s_pd_release;
        $rose(pd_up) ##1 !word_present;
    endsequence

    a_ctrl_write: assert property (@(posedge MCLK) disable iff (!ARST_N)
        s_ctrl_write |=> (ctrl_q == $past(PWDATA[3:0])))
        else $error("control write not stored");
    a_pd_defaults: assert property (@(posedge MCLK) disable iff (!ARST_N)
        !pd_up |=> (ctrl_q == CTRL_RESET))
        else $error("config not at defaults in power-down");
    a_auto_speed: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (speed_sel == SPEED_AUTO && $stable(detect_q)) |=> (ACTIVE_SPEED == $past(detect_q)))
        else $error("auto mode does not follow detection");
    a_ratio_class: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (pd_up && word_rise && cnt_q != 12'h000)
        |=> (ratio_q == $past(cnt_q)) && (detect_q == classify_ratio($past(cnt_q))))
        else $error("ratio measurement wrong");
    a_pd_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
        !pd_up |=> DATAPATH_RESET && (state_q == ST_DOWN))
        else $error("power-down does not reset datapath");
    a_wait_clocks: assert property (@(posedge MCLK) disable iff (!ARST_N)
        s_pd_release |-> DATAPATH_RESET[*2])
        else $error("left reset before clocks were present");
    a_mid_level: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (state_q != ST_RUN) |-> MID_LEVEL_OUT)
        else $error("reset without mid level output");
    a_lost_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (lost_s && pd_up) |-> ##[1:2] DATAPATH_RESET)
        else $error("master clock loss not reset");
    a_pair_once: assert property (@(posedge MCLK) disable iff (!ARST_N)
        SAMPLE_VALID |=> !SAMPLE_VALID && $stable(SAMPLE_LEFT))
        else $error("stereo pair presented twice");
    a_watchdog: assert property (@(posedge SERIAL_BIT_CLOCK) disable iff (!ARST_N)
        (!pd_link) |=> !lost_q)
        else $error("watchdog active during power-down");
endmodule // audio_serial_input

`default_nettype wire

// [audio_serial_input_tb.sv]
/*
 * self-checking bench for the serial audio input block.
 * assumes audio_host drives the link pins and apb answers at once.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_serial_input_tb;
    import audio_in_pkg::*;
    logic MCLK, ARST_N, PSEL, PENABLE, PWRITE, POWER_DOWN_PIN_N, run, mstop, er;
    logic PREADY, PSLVERR, SAMPLE_VALID, DATAPATH_RESET, MID_LEVEL_OUT, bck, wc, sd;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [23:0] SAMPLE_LEFT, SAMPLE_RIGHT;
    logic [1:0] ACTIVE_SPEED, hfmt;
    logic [11:0] ratio;
    logic [1:0] slist [6] = '{SPEED_NORMAL, SPEED_DOUBLE, SPEED_HALF, SPEED_AUTO, SPEED_AUTO,
        SPEED_AUTO};
    logic [1:0] xlist [6] = '{SPEED_NORMAL, SPEED_DOUBLE, SPEED_HALF, SPEED_NORMAL, SPEED_DOUBLE,
        SPEED_HALF};
    logic [11:0] rlist [6] = '{12'h200, 12'h080, 12'h600, 12'h300, 12'h180, 12'h400};
    int errors, comparisons, cycles;

    audio_host audio_host_inst (.run(run), .fmt(hfmt), .ratio(ratio), .left(24'h812345),
        .right(24'h7EDCBA), .bck(bck), .wc(wc), .sd(sd));
    audio_serial_input audio_serial_input_inst (.MCLK, .ARST_N, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .POWER_DOWN_PIN_N,
        .SERIAL_BIT_CLOCK(bck), .CHANNEL_WORD_CLOCK(wc), .SERIAL_SAMPLE_INPUT(sd),
        .SAMPLE_LEFT, .SAMPLE_RIGHT, .SAMPLE_VALID, .ACTIVE_SPEED, .DATAPATH_RESET,
        .MID_LEVEL_OUT);

    // ------------------------------------------------------------
    // clock and timeout
    // ------------------------------------------------------------
    initial begin
        MCLK = 1'b0;
        forever begin
            #50;
            if (!mstop) MCLK = ~MCLK;
        end
    end
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wait_valid();
        repeat (2000) begin
            @(posedge MCLK);
            if (SAMPLE_VALID === 1'b1) break;
        end
        chk(SAMPLE_VALID, 1);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {ARST_N, PSEL, PENABLE, PWRITE, POWER_DOWN_PIN_N, run, mstop} = '0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        hfmt = FMT_LSB16;
        ratio = 12'h200;
        repeat (16) @(posedge MCLK);
        ARST_N <= 1'b1;
        POWER_DOWN_PIN_N <= 1'b1;
        repeat (300) @(posedge MCLK);
        chk(DATAPATH_RESET, 1);
        $display("test no clocks done");
        run <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            hfmt <= s[1:0];
            ratio <= rlist[s];
            apb(1'b1, CTRL_OFFSET, {28'h0, s[1:0], slist[s]});
            repeat (3 * rlist[s] + 800) @(posedge MCLK);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk(rd[1:0], xlist[s]);
            apb(1'b0, RATIO_OFFSET, 32'h0);
            chk(rd[11:0], rlist[s]);
            wait_valid();
            wait_valid();
            chk(SAMPLE_LEFT, (s % 4 == 0) ? 24'h812300 : 24'h812345);
            chk(SAMPLE_RIGHT, (s % 4 == 0) ? 24'h7EDC00 : 24'h7EDCBA);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test stream done");
        ratio <= 12'h080;
        repeat (800) @(posedge MCLK);
        mstop = 1'b1;
        #60000;
        chk(MID_LEVEL_OUT, 1);
        mstop = 1'b0;
        repeat (200) @(posedge MCLK);
        chk(MID_LEVEL_OUT, 0);
        chk(DATAPATH_RESET, 0);
        POWER_DOWN_PIN_N <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk(DATAPATH_RESET, 1);
        apb(1'b1, CTRL_OFFSET, 32'h0000000F);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        chk(ACTIVE_SPEED, SPEED_NORMAL);
        $display("test power down done");
        finish_test();
    end
endmodule // audio_serial_input_tb

`default_nettype wire

// [serial_deframer.sv]
/*
 * bit clock domain deserialiser: word clock framing, four formats.
 * assumes word clock and data change away from rising bit clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_deframer import audio_in_pkg::*; (
    // link clock
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clear,
    // configuration
    input wire logic [1:0] fmt,
    // pins
    input wire logic word_in,
    input wire logic data_in,
    // assembled pair
    output logic [23:0] left,
    output logic [23:0] right,
    output logic pair_toggle
);
    logic wc_prev_q;
    logic [23:0] sr_q;
    logic [4:0] n_q;
    logic left_seen_q;
    logic change;
    logic ending_left;
    logic [23:0] word_d;

    function automatic logic [23:0] align(input logic [23:0] v, input logic [4:0] n);
        align = v << (5'd24 - n);
    endfunction

    assign change = word_in != wc_prev_q;
    assign ending_left = (fmt == FMT_I2S) ? !wc_prev_q : wc_prev_q;

    always_comb begin
        unique case (fmt)
            FMT_LSB16: word_d = {sr_q[15:0], 8'h00};
            FMT_LSB24: word_d = sr_q;
            FMT_MSB24: word_d = align(sr_q, n_q);
            FMT_I2S: word_d = (n_q < 5'd24) ? align({sr_q[22:0], data_in}, n_q + 5'd1)
                                            : sr_q;
        endcase
    end

    // ------------------------------------------------------------
    // shifting
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wc_prev_q <= 1'b0;
            sr_q <= 24'h000000;
            n_q <= 5'h00;
        end else if (clear) begin
            wc_prev_q <= word_in;
            sr_q <= 24'h000000;
            n_q <= 5'h00;
        end else begin
            wc_prev_q <= word_in;
            if (fmt == FMT_LSB16 || fmt == FMT_LSB24) begin
                sr_q <= {sr_q[22:0], data_in};
            end else if (change) begin
                sr_q <= (fmt == FMT_MSB24) ? {23'h000000, data_in} : 24'h000000;
                n_q <= (fmt == FMT_MSB24) ? 5'h01 : 5'h00;
            end else if (n_q < 5'd24) begin
                sr_q <= {sr_q[22:0], data_in};
                n_q <= n_q + 5'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // channel capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left <= 24'h000000;
            right <= 24'h000000;
            pair_toggle <= 1'b0;
            left_seen_q <= 1'b0;
        end else if (clear) begin
            left_seen_q <= 1'b0;
        end else if (change) begin
            if (ending_left) begin
                left <= word_d;
                left_seen_q <= 1'b1;
            end else if (left_seen_q) begin
                right <= word_d;
                pair_toggle <= ~pair_toggle;
                left_seen_q <= 1'b0;
            end
        end
    end

    a_shift_msb_first: assert property (@(posedge clk) disable iff (!arst_n)
        (!clear && !change && fmt == FMT_MSB24 && n_q < 5'd24)
        |=> (sr_q == {$past(sr_q[22:0]), $past(data_in)}))
        else $error("serial bit not shifted in msb first");
    a_lsb24_capture: assert property (@(posedge clk) disable iff (!arst_n)
        (!clear && change && ending_left && fmt == FMT_LSB24) |=> (left == $past(sr_q)))
        else $error("lsb justified word captured wrongly");
endmodule // serial_deframer

`default_nettype wire

// [sync_bit.sv]
/*
 * two flip-flop level synchroniser.
 * assumes the input is a level that stays for several destination clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_bit (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // level
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync_bit

`default_nettype wire
